// *** rtl/upmc_power_ctrl.sv ***
// Summary of operation
// (RULE1) reset sets low-clock enable, reduced rate
// (RULE2) clearing low-clock returns to selected rate
// (RULE3) idle beyond 3 ms is global suspend
// (RULE4) suspend sets suspend flag, firmware clears
// (RULE5) resume sets resume flag, ORed interrupt
// (RULE6) own wake-up never sets resume flag
// (RULE7) wake bit drives resume, self-clears
// (RULE8) firmware wakes only while suspended; code accepts the wake bit at any time
// (RULE9) reset unisolated: bus reset resets chip
// (RULE10) isolated: reset usb only, flag, interrupt
// (RULE11) reset flag sets regardless, joins interrupt; code sets it only while isolated
// (RULE12) powerdown bit enters powerdown, cleared by interrupt
// (RULE13) idle bit enters idle; powerdown wins
// (RULE14) firmware powers down only after suspend; code accepts the powerdown bit at any time
// (RULE15) supply rise sets power-off flag, writable
// (RULE16) bit 6 steers serial bit 7 access
// (RULE17) baud doubler doubles timer1 modes 1-3
// (RULE18) bits 3,2 are general flags
// (RULE19) firmware handles resume before suspend
// (RULE20) test mode releases all output pins
// (RULE21) hardware set beats firmware clear
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module upmc_power_ctrl
    import upmc_pkg::*;
#(
    parameter int SUSPEND_LIMIT = SUSPEND_CYCLES,
    parameter int RESUME_LIMIT = RESUME_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial engine and chip status
    input wire upmc_bus_t bus_state,
    input wire logic supply_rise,
    input wire logic core_int,
    input wire logic test_mode,
    input wire logic timer1_baud_src,
    input wire logic [1:0] serial_mode,
    input wire logic [2:0] pll_select_pins,
    // outputs
    output upmc_mode_t mode,
    output logic [2:0] clk_select,
    output logic baud_double_active,
    output logic resume_drive,
    output logic chip_reset,
    output logic usb_block_reset,
    output logic usb_pwr_irq,
    output logic usb_reset_irq,
    output logic pins_release
);
    logic [7:0] power_control;
    logic [7:0] usb_power_control;
    logic framing_error_flag;
    logic serial_mode_bit0;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_held;
    logic w_held;
    logic do_write;
    logic suspend_expired;
    logic suspend_prev;
    logic suspend_event;
    logic resume_event;
    logic reset_prev;
    logic reset_event;
    logic wr_pc;
    logic wr_uc;
    logic wr_sc;
    logic [7:0] wbyte;
    upmc_wake_t wake_state;
    logic [31:0] wake_count;
    logic [5:0] chip_count;

    function automatic logic [7:0] lane0(input logic [31:0] d, input logic [3:0] s,
                                         input logic [7:0] old);
        lane0 = s[0] ? d[7:0] : old;
    endfunction

    upmc_idle_timer #(.LIMIT(SUSPEND_LIMIT)) u_idle_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .line_idle(bus_state.line_idle),
        .expired(suspend_expired)
    );

    // event edges from the serial engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            suspend_prev <= 1'b0;
            reset_prev <= 1'b0;
        end else begin
            suspend_prev <= suspend_expired;
            reset_prev <= bus_state.bus_reset;
        end
    end
    assign suspend_event = suspend_expired && !suspend_prev; // RULE3
    assign reset_event = bus_state.bus_reset && !reset_prev;
    // resume caused by our own wake-up is ignored
    assign resume_event = bus_state.resume_seen && wake_state == WK_IDLE; // RULE6

    // write channel capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_pc || wr_uc || wr_sc || aw_addr == SUPPLY_CTRL_ADDR
                                || aw_addr == STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wbyte = lane0(w_data, w_strb, power_control);

    // ready flags from flops, low while a capture or a response is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !do_write && !(aw_held || (s_axi_awvalid && s_axi_awready))
                             && !(s_axi_bvalid && !s_axi_bready);
            s_axi_wready <= !do_write && !(w_held || (s_axi_wvalid && s_axi_wready))
                            && !(s_axi_bvalid && !s_axi_bready);
            s_axi_arready <= !(s_axi_arvalid && s_axi_arready)
                             && !(s_axi_rvalid && !s_axi_rready);
        end
    end

    // register select strobes
    assign wr_pc = do_write && aw_addr == PWR_CTRL_ADDR;
    assign wr_uc = do_write && aw_addr == USB_PWR_CTRL_ADDR;
    assign wr_sc = do_write && aw_addr == SER_CTRL7_ADDR;

    // power control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_control <= PC_RESET; // RULE1
        end else begin
            if (wr_pc) begin
                power_control <= wbyte; // RULE2 RULE18
            end
            // interrupt events wake the core; usb levels are not used, so
            // firmware can still enter powerdown while the suspend flag stands
            if (core_int || suspend_event || resume_event || reset_event) begin
                power_control[PC_PD] <= 1'b0; // RULE12
                power_control[PC_IDLE] <= 1'b0; // RULE13
            end
            if (supply_rise) begin
                power_control[PC_POF] <= 1'b1; // RULE15 RULE21
            end
        end
    end

    // serial control bit 7 pair, steered by bit 6
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            framing_error_flag <= 1'b0;
            serial_mode_bit0 <= 1'b0;
        end else if (wr_sc && w_strb[0]) begin
            if (power_control[PC_FESEL]) begin
                framing_error_flag <= w_data[7]; // RULE16
            end else begin
                serial_mode_bit0 <= w_data[7]; // RULE16
            end
        end
    end

    // usb power control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_power_control <= UC_RESET;
        end else begin
            if (wr_uc && w_strb[0]) begin
                usb_power_control <= w_data[7:0] & UC_WMASK;
                // write of 1 sets the wake request at any time; a write of 0 leaves it set
                usb_power_control[UC_RWU] <= w_data[UC_RWU] | usb_power_control[UC_RWU];
            end
            if (wake_state == WK_DONE) begin
                usb_power_control[UC_RWU] <= 1'b0; // RULE7
            end
            if (suspend_event) begin
                usb_power_control[UC_GLOBAL_SUSPEND_FLAG] <= 1'b1; // RULE4 RULE21
            end
            if (resume_event) begin
                usb_power_control[UC_GLOBAL_RESUME_FLAG] <= 1'b1; // RULE5 RULE21
            end
            if (reset_event && usb_power_control[UC_ISO]) begin
                usb_power_control[UC_USB_RESET_FLAG] <= 1'b1; // RULE10 RULE11 RULE21
            end
        end
    end

    // remote wake-up signalling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_state <= WK_IDLE;
            wake_count <= 32'h0000_0000;
            resume_drive <= 1'b0;
        end else begin
            case (wake_state)
                WK_IDLE: begin
                    if (usb_power_control[UC_RWU]) begin
                        wake_state <= WK_DRIVE; // RULE7
                        wake_count <= 32'h0000_0000;
                        resume_drive <= 1'b1;
                    end
                end
                WK_DRIVE: begin
                    wake_count <= wake_count + 32'h0000_0001;
                    if (wake_count + 32'h0000_0001 >= RESUME_LIMIT[31:0]) begin
                        wake_state <= WK_DONE;
                        resume_drive <= 1'b0;
                    end
                end
                WK_DONE: begin
                    wake_state <= WK_IDLE;
                end
                default: begin
                    wake_state <= WK_IDLE;
                    resume_drive <= 1'b0;
                end
            endcase
        end
    end

    // usb reset routing and chip reset stretch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chip_count <= 6'h00;
            chip_reset <= 1'b0;
            usb_block_reset <= 1'b0;
        end else begin
            usb_block_reset <= bus_state.bus_reset; // RULE10
            if (reset_event && !usb_power_control[UC_ISO]) begin
                chip_count <= 6'(CHIP_RESET_CYCLES); // RULE9
                chip_reset <= 1'b1;
            end else if (chip_count != 6'h00) begin
                chip_count <= chip_count - 6'h01;
                chip_reset <= chip_count != 6'h01;
            end
        end
    end

    // registered mode and interrupt outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= '0;
            clk_select <= 3'h0;
            baud_double_active <= 1'b0;
            usb_pwr_irq <= 1'b0;
            usb_reset_irq <= 1'b0;
            pins_release <= 1'b0;
        end else begin
            mode.low_clock_enable <= power_control[PC_LC]; // RULE1 RULE2
            clk_select <= pll_select_pins; // RULE2
            mode.powerdown_mode <= power_control[PC_PD]; // RULE12
            mode.idle_mode <= power_control[PC_IDLE] && !power_control[PC_PD]; // RULE13
            mode.baud_doubler <= power_control[PC_BAUD2];
            mode.frame_err_select <= power_control[PC_FESEL];
            baud_double_active <= power_control[PC_BAUD2] && timer1_baud_src
                                  && serial_mode != 2'b00; // RULE17
            usb_pwr_irq <= usb_power_control[UC_GLOBAL_SUSPEND_FLAG] | usb_power_control[UC_GLOBAL_RESUME_FLAG]
                           | usb_power_control[UC_USB_RESET_FLAG]; // RULE5 RULE11
            usb_reset_irq <= usb_power_control[UC_USB_RESET_FLAG]; // RULE10
            pins_release <= test_mode; // RULE20
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                PWR_CTRL_ADDR: s_axi_rdata <= {24'h00_0000, power_control};
                USB_PWR_CTRL_ADDR: s_axi_rdata <= {24'h00_0000, usb_power_control};
                SER_CTRL7_ADDR: s_axi_rdata <= {24'h00_0000, power_control[PC_FESEL]
                    ? framing_error_flag : serial_mode_bit0, 7'h00}; // RULE16
                STATUS_ADDR: s_axi_rdata <= {26'h000_0000, resume_drive, chip_reset,
                    suspend_expired, mode.powerdown_mode, mode.idle_mode,
                    mode.low_clock_enable};
                SUPPLY_CTRL_ADDR: s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** rtl/upmc_pkg.sv ***
package upmc_pkg;
    // register byte addresses (printed offsets 0x87 and 0xdf are not word aligned)
    localparam logic [7:0] PWR_CTRL_IDX = 8'h87;
    localparam logic [7:0] USB_PWR_CTRL_IDX = 8'hdf;
    localparam logic [11:0] PWR_CTRL_ADDR = {2'b00, PWR_CTRL_IDX, 2'b00};
    localparam logic [11:0] USB_PWR_CTRL_ADDR = {2'b00, USB_PWR_CTRL_IDX, 2'b00};
    localparam logic [11:0] SER_CTRL7_ADDR = 12'h0400;
    localparam logic [11:0] STATUS_ADDR = 12'h0404;
    localparam logic [11:0] SUPPLY_CTRL_ADDR = 12'h0408;
    // power control fields
    localparam int PC_IDLE = 0;
    localparam int PC_PD = 1;
    localparam int PC_GF0 = 2;
    localparam int PC_GF1 = 3;
    localparam int PC_POF = 4;
    localparam int PC_LC = 5;
    localparam int PC_FESEL = 6;
    localparam int PC_BAUD2 = 7;
    // usb power control fields
    localparam int UC_GLOBAL_SUSPEND_FLAG = 0;
    localparam int UC_GLOBAL_RESUME_FLAG = 1;
    localparam int UC_RWU = 2;
    localparam int UC_USB_RESET_FLAG = 3;
    localparam int UC_ISO = 4;
    localparam logic [7:0] PC_RESET = 8'h20;
    localparam logic [7:0] UC_RESET = 8'h00;
    localparam logic [7:0] UC_WMASK = 8'h1f;
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SUSPEND_TIME_US = 3000;
    localparam int SUSPEND_CYCLES = SUSPEND_TIME_US * (1000000 / CLK_PERIOD_PS) + 1;
    localparam int RESUME_TIME_US = 2000;
    localparam int RESUME_CYCLES = RESUME_TIME_US * (1000000 / CLK_PERIOD_PS);
    localparam int CHIP_RESET_CYCLES = 32;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // bus states reported by the serial engine
    typedef struct packed {
        logic line_idle;
        logic resume_seen;
        logic bus_reset;
    } upmc_bus_t;

    // clock and mode outputs
    typedef struct packed {
        logic low_clock_enable;
        logic idle_mode;
        logic powerdown_mode;
        logic baud_doubler;
        logic frame_err_select;
    } upmc_mode_t;

    typedef enum logic [1:0] {WK_IDLE, WK_DRIVE, WK_DONE} upmc_wake_t;
endpackage

// *** rtl/upmc_idle_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module upmc_idle_timer
    import upmc_pkg::*;
#(
    parameter int LIMIT = SUSPEND_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // line state
    input wire logic line_idle,
    // result
    output logic expired
);
    logic [31:0] count;

    // counts continuous idle, restarts on any activity
    always_ff @(posedge aclk) begin
        if (!aresetn || !line_idle) begin
            count <= 32'h0000_0000;
            expired <= 1'b0;
        end else if (count < LIMIT[31:0]) begin
            count <= count + 32'h0000_0001;
            expired <= (count + 32'h0000_0001) >= LIMIT[31:0];
        end
    end
endmodule
`default_nettype wire

// *** bench/upmc_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module upmc_assertions
    import upmc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // status inputs
    input wire upmc_bus_t bus_state,
    input wire logic core_int,
    input wire logic test_mode,
    // outputs
    input wire upmc_mode_t mode,
    input wire logic chip_reset,
    input wire logic usb_block_reset,
    input wire logic usb_pwr_irq,
    input wire logic usb_reset_irq,
    input wire logic pins_release
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    int rst_len;
    // length of the running chip reset pulse
    always_ff @(posedge aclk) begin
        rst_len <= (aresetn && chip_reset) ? rst_len + 1 : 0;
    end
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_write_taken |=> ##1 s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
        else $error("read response missing");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_low_clock_boot: assert property (
        $rose(aresetn) |-> ##[1:2] mode.low_clock_enable) else $error("low clock off");
    a_powerdown_wins: assert property (
        mode.powerdown_mode |-> !mode.idle_mode) else $error("idle beside powerdown");
    a_int_wakes_core: assert property (
        core_int |-> ##[1:2] !mode.powerdown_mode && !mode.idle_mode)
        else $error("interrupt left sleep mode");
    a_block_reset: assert property (
        $rose(bus_state.bus_reset) |=> usb_block_reset) else $error("no usb reset");
    a_chip_reset_len: assert property (
        $fell(chip_reset) |-> rst_len == CHIP_RESET_CYCLES) else $error("chip reset length");
    a_reset_irq_joins: assert property (
        usb_reset_irq |-> usb_pwr_irq) else $error("reset flag not in irq");
    a_pins_released: assert property (
        test_mode [*2] |-> pins_release) else $error("pins not released");
endmodule
bind upmc_power_ctrl upmc_assertions i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .bus_state, .core_int, .test_mode, .mode, .chip_reset,
    .usb_block_reset, .usb_pwr_irq, .usb_reset_irq, .pins_release);
`default_nettype wire

// *** bench/upmc_sie_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module upmc_sie_model
    import upmc_pkg::*;
(
    // scenario: 0 traffic, 1 idle, 2 resume, 3 bus reset
    input wire logic [1:0] cmd,
    // wake-up drive from the device
    input wire logic resume_drive,
    // reported bus state
    output upmc_bus_t bus_state
);
    // our own drive shows on the wire as resume and breaks idle
    assign bus_state = {(cmd == 2'h1) && !resume_drive, (cmd == 2'h2) || resume_drive,
                        cmd == 2'h3};
endmodule
`default_nettype wire

// *** bench/usb_mcu_power_mode_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module usb_mcu_power_mode_control_tb
    import upmc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, cmd = 2'h0, serial_mode = 2'h0;
    logic [31:0] s_axi_rdata, rd;
    logic supply_rise = 1'b0, core_int = 1'b0, test_mode = 1'b0, timer1_baud_src = 1'b0;
    logic [2:0] pll_select_pins = 3'h5, clk_select;
    upmc_bus_t bus_state;
    upmc_mode_t mode;
    logic baud_double_active, resume_drive, chip_reset, usb_block_reset;
    logic usb_pwr_irq, usb_reset_irq, pins_release;
    int miscompares = 0;
    int n_tests = 0;

    always #2.5 aclk = ~aclk;

    upmc_power_ctrl #(.SUSPEND_LIMIT(20), .RESUME_LIMIT(10)) i_dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .bus_state, .supply_rise, .core_int, .test_mode,
        .timer1_baud_src, .serial_mode, .pll_select_pins, .mode, .clk_select,
        .baud_double_active, .resume_drive, .chip_reset, .usb_block_reset,
        .usb_pwr_irq, .usb_reset_irq, .pins_release);
    upmc_sie_model i_sie (.cmd, .resume_drive, .bus_state);

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one bus transfer; handshakes judged from settled values before the edge
    task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d);
        logic aw_hs, w_hs, ar_hs, done;
        int t;
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h00_0000, d};
            s_axi_wstrb <= 4'h1;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        done = 1'b0;
        for (t = 0; t < 100 && !done; t++) begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            ar_hs = s_axi_arvalid && s_axi_arready;
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            resp = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (ar_hs) s_axi_arvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!done) begin
            miscompares++;
            $display("BAD at %0t: bus answer timed out", $time);
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 8'h00);
        chk(rd, exp);
        chk(32'(resp), 32'(RESP_OKAY));
    endtask

    // wait n edges, then settle at the falling edge
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask

    // firmware sequence
    initial begin
        int m;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(3);
        chk(32'(mode.low_clock_enable), 32'h0000_0001);
        rchk(PWR_CTRL_ADDR, 32'(PC_RESET));
        rchk(USB_PWR_CTRL_ADDR, 32'(UC_RESET));
        acc(1'b1, PWR_CTRL_ADDR, 8'h0c);
        cyc(2);
        chk(32'(mode.low_clock_enable), 32'h0000_0000);
        chk(32'(clk_select), 32'(pll_select_pins));
        rchk(PWR_CTRL_ADDR, 32'h0000_000c);
        @(posedge aclk);
        supply_rise <= 1'b1;
        @(posedge aclk);
        supply_rise <= 1'b0;
        rchk(PWR_CTRL_ADDR, 32'h0000_001c);
        acc(1'b1, PWR_CTRL_ADDR, 8'h40);
        rchk(PWR_CTRL_ADDR, 32'h0000_0040);
        acc(1'b1, SER_CTRL7_ADDR, 8'h80);
        rchk(SER_CTRL7_ADDR, 32'h0000_0080);
        acc(1'b1, PWR_CTRL_ADDR, 8'h80);
        rchk(SER_CTRL7_ADDR, 32'h0000_0000);
        timer1_baud_src <= 1'b1;
        for (m = 0; m < 5; m++) begin
            @(posedge aclk);
            serial_mode <= 2'(m);
            timer1_baud_src <= (m < 4);
            cyc(3);
            chk(32'(baud_double_active), 32'(m == 1 || m == 2 || m == 3));
        end
        chk(32'({mode.baud_doubler, mode.frame_err_select}), 32'h0000_0002);
        acc(1'b1, PWR_CTRL_ADDR, 8'h03);
        cyc(2);
        chk(32'({mode.powerdown_mode, mode.idle_mode}), 32'h0000_0002);
        @(posedge aclk);
        core_int <= 1'b1;
        @(posedge aclk);
        core_int <= 1'b0;
        rchk(PWR_CTRL_ADDR, 32'h0000_0000);
        @(posedge aclk);
        cmd <= 2'h1;
        cyc(15);
        rchk(USB_PWR_CTRL_ADDR, 32'h0000_0000);
        cyc(20);
        rchk(USB_PWR_CTRL_ADDR, 32'h0000_0001);
        acc(1'b1, PWR_CTRL_ADDR, 8'h02);
        cyc(1);
        chk(32'(mode.powerdown_mode), 32'h0000_0001);
        @(posedge aclk);
        cmd <= 2'h2;
        cyc(4);
        chk(32'({usb_pwr_irq, mode.powerdown_mode}), 32'h0000_0002);
        rchk(USB_PWR_CTRL_ADDR, 32'h0000_0003);
        cmd <= 2'h1;
        acc(1'b1, USB_PWR_CTRL_ADDR, 8'h00);
        cyc(40);
        rchk(USB_PWR_CTRL_ADDR, 32'h0000_0001);
        acc(1'b1, USB_PWR_CTRL_ADDR, 8'h05);
        cyc(1);
        chk(32'(resume_drive), 32'h0000_0001);
        for (m = 0; m < 50 && resume_drive === 1'b1; m++) cyc(1);
        chk(32'(m), 32'h0000_0009);
        rchk(USB_PWR_CTRL_ADDR, 32'h0000_0001);
        acc(1'b1, USB_PWR_CTRL_ADDR, 8'h10);
        cmd <= 2'h3;
        cyc(4);
        chk(32'({chip_reset, usb_block_reset, usb_reset_irq}), 32'h0000_0003);
        @(posedge aclk);
        cmd <= 2'h0;
        acc(1'b0, USB_PWR_CTRL_ADDR, 8'h00);
        chk(32'(rd[3]), 32'h0000_0001);
        acc(1'b1, USB_PWR_CTRL_ADDR, 8'h00);
        cmd <= 2'h3;
        cyc(4);
        chk(32'({chip_reset, usb_reset_irq}), 32'h0000_0002);
        @(posedge aclk);
        cmd <= 2'h0;
        for (m = 0; m < 60 && chip_reset === 1'b1; m++) cyc(1);
        @(posedge aclk);
        test_mode <= 1'b1;
        cyc(3);
        chk(32'(pins_release), 32'h0000_0001);
        rchk(SUPPLY_CTRL_ADDR, 32'h0000_0000);
        acc(1'b0, 12'hff0, 8'h00);
        chk({rd[29:0], resp}, {30'h0, RESP_SLVERR});
        acc(1'b1, 12'hff0, 8'h00);
        chk(32'(resp), 32'(RESP_SLVERR));
        final_report();
    end

    // watchdog far beyond the expected run
    initial begin
        #100000;
        miscompares++;
        $display("BAD at %0t: watchdog expired", $time);
        final_report();
    end
endmodule
`default_nettype wire
